/* inc/fcs_pkg.sv */
// constants, codes and types shared by the flash command sequencer host
package fcs_pkg;

   // ----------------------------------------------------------------
   // command codes written into the device command register, and the erased byte value
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_RESET      = 8'hff;
   localparam logic [7:0] CMD_IDENT      = 8'h90;
   localparam logic [7:0] CMD_ERASE      = 8'h30;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h10;
   localparam logic [7:0] ERASED_BYTE    = 8'hff;

   // ----------------------------------------------------------------
   // status bit positions on the data bus
   // ----------------------------------------------------------------
   localparam int STATUS_BIT_SEVEN   = 7;
   localparam int TIMEOUT_STATUS_BIT = 5;

   // ----------------------------------------------------------------
   // timing, 40 mhz core clock
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ   = 40000;
   localparam int unsigned T_WE_NS   = 50;
   localparam int unsigned T_ACC_NS  = 150;
   localparam int unsigned T_RAMP_NS = 500;
   // least times, rounded up to whole cycles
   localparam logic [7:0]  WE_CYC    = 8'((T_WE_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [7:0]  ACC_CYC   = 8'((T_ACC_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [7:0]  RAMP_CYC  = 8'((T_RAMP_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [7:0]  CNT_ONE   = 8'h01;

   // ----------------------------------------------------------------
   // user operations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ  = 3'b000,
      OP_IDENT = 3'b001,
      OP_ERASE = 3'b010,
      OP_PROG  = 3'b011,
      OP_RESET = 3'b100
   } fcs_op_t;

endpackage

/* inc/fcs_bus_if.sv */
// request and answer carrier between sequencer and pin cycle engine
`timescale 1ns/1ps
interface fcs_bus_if #(parameter int ADDR_W = 18);
   logic              req;
   logic              is_wr;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata;
   logic              ack;
   logic [7:0]        rdata;

   modport ctl (output req, output is_wr, output addr, output wdata,
                input ack, input rdata);
   modport eng (input req, input is_wr, input addr, input wdata,
                output ack, output rdata);
endinterface

/* design/fcs_cycle.sv */
// pin cycle engine: one write or read bus cycle per request
`timescale 1ns/1ps
module fcs_cycle
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 18
)(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   fcs_bus_if.eng                 bus,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_in
);
   import fcs_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      E_IDLE  = 3'b000,
      E_SETUP = 3'b001,
      E_WLOW  = 3'b010,
      E_WHOLD = 3'b011,
      E_RWAIT = 3'b100
   } fcs_est_t;

   typedef struct packed {
      fcs_est_t          st;
      logic [7:0]        cnt;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              dq_oe;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        dq;
      logic [7:0]        rdata;
      logic              ack;
   } fcs_eng_t;

   fcs_eng_t s_q;
   fcs_eng_t s_d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d     = s_q;
      s_d.ack = 1'b0;
      case (s_q.st)
         E_IDLE:
         begin
            if (bus.req && !s_q.ack)
            begin
               s_d.addr = bus.addr;
               s_d.ce_n = 1'b0;
               if (bus.is_wr)
               begin
                  // oe stays high through a write, else the device drops it
                  s_d.dq    = bus.wdata;
                  s_d.dq_oe = 1'b1;
                  s_d.st    = E_SETUP;
               end
               else
               begin
                  s_d.oe_n = 1'b0;
                  s_d.cnt  = ACC_CYC;
                  s_d.st   = E_RWAIT;
               end
            end
         end
         E_SETUP:
         begin
            // address settles before we falls, where it is captured
            s_d.we_n = 1'b0;
            s_d.cnt  = WE_CYC;
            s_d.st   = E_WLOW;
         end
         E_WLOW:
         begin
            if (s_q.cnt == CNT_ONE)
            begin
               // we rises before ce, so the we rise latches the data
               s_d.we_n = 1'b1;
               s_d.st   = E_WHOLD;
            end
            else
               s_d.cnt = s_q.cnt - CNT_ONE;
         end
         E_WHOLD:
         begin
            // data held one cycle past the we rise
            s_d.ce_n  = 1'b1;
            s_d.dq_oe = 1'b0;
            s_d.ack   = 1'b1;
            s_d.st    = E_IDLE;
         end
         E_RWAIT:
         begin
            if (s_q.cnt == CNT_ONE)
            begin
               s_d.rdata = flash_dq_in;
               s_d.ce_n  = 1'b1;
               s_d.oe_n  = 1'b1;
               s_d.ack   = 1'b1;
               s_d.st    = E_IDLE;
            end
            else
               s_d.cnt = s_q.cnt - CNT_ONE;
         end
         default:
            s_d.st = E_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         s_q       <= '0;
         s_q.st    <= E_IDLE;
         s_q.ce_n  <= 1'b1;
         s_q.oe_n  <= 1'b1;
         s_q.we_n  <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign flash_ce_n   = s_q.ce_n;
   assign flash_oe_n   = s_q.oe_n;
   assign flash_we_n   = s_q.we_n;
   assign flash_addr   = s_q.addr;
   assign flash_dq_out = s_q.dq;
   assign flash_dq_oe  = s_q.dq_oe;
   assign bus.ack      = s_q.ack;
   assign bus.rdata    = s_q.rdata;
endmodule

/* design/fcs_host.sv */
// host-side sequencer that drives a byte-wide bulk-erase flash by its pins
`timescale 1ns/1ps
module fcs_host
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 18
)(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              cmd_valid,
   input  wire fcs_pkg::fcs_op_t  cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [7:0]        cmd_data,
   output logic                   busy,
   output logic                   done,
   output logic                   fail,
   output logic [7:0]             result,
   output logic                   programming_supply,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_in
);
   import fcs_pkg::*;

   generate
      if (ADDR_W < 1 || ADDR_W > 24)
      begin : g_bad_width
         $error("fcs_host: ADDR_W must lie in 1..24");
      end
   endgenerate

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      M_IDLE   = 4'b0000,
      M_RAMP   = 4'b0001,
      M_W1     = 4'b0010,
      M_W2     = 4'b0011,
      M_RD     = 4'b0100,
      M_POLL   = 4'b0101,
      M_REPOLL = 4'b0110,
      M_VERIFY = 4'b0111,
      M_EXIT   = 4'b1000,
      M_FIN    = 4'b1001
   } fcs_mst_t;

   typedef struct packed {
      fcs_mst_t          st;
      fcs_op_t           op;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic [7:0]        cnt;
      logic              req;
      logic              is_wr;
      logic [ADDR_W-1:0] baddr;
      logic [7:0]        bdata;
      logic              busy;
      logic              done;
      logic              fail;
      logic [7:0]        result;
      logic              vpp;
   } fcs_host_t;

   fcs_host_t s_q;
   fcs_host_t s_d;

   fcs_bus_if #(.ADDR_W(ADDR_W)) bus ();

   fcs_cycle #(.ADDR_W(ADDR_W)) u_cycle (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .bus          (bus.eng),
      .flash_ce_n   (flash_ce_n),
      .flash_oe_n   (flash_oe_n),
      .flash_we_n   (flash_we_n),
      .flash_addr   (flash_addr),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe),
      .flash_dq_in  (flash_dq_in)
   );

   // completion test on bit seven of a poll read
   logic poll_ok;
   always_comb
   begin
      if (s_q.op == OP_PROG)
         poll_ok = bus.rdata[STATUS_BIT_SEVEN] == s_q.data[STATUS_BIT_SEVEN];
      else
         poll_ok = bus.rdata[STATUS_BIT_SEVEN];
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         M_IDLE:
         begin
            if (cmd_valid)
            begin
               s_d.op    = cmd_op;
               s_d.addr  = cmd_addr;
               s_d.data  = cmd_data;
               s_d.busy  = 1'b1;
               s_d.fail  = 1'b0;
               s_d.cnt   = RAMP_CYC;
               s_d.baddr = cmd_addr;
               if (cmd_op == OP_READ)
                  s_d.st = M_RD;    // supply low keeps the device in read mode
               else
               begin
                  s_d.vpp = 1'b1;   // command register only listens with supply high
                  s_d.st  = M_RAMP;
               end
            end
         end
         M_RAMP:
         begin
            if (s_q.cnt == CNT_ONE)
               s_d.st = M_W1;
            else
               s_d.cnt = s_q.cnt - CNT_ONE;
         end
         M_W1:
         begin
            // first write picks the operation
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b1;
            case (s_q.op)
               OP_ERASE: s_d.bdata = CMD_ERASE;
               OP_PROG:  s_d.bdata = CMD_PROG_SETUP;
               OP_IDENT: s_d.bdata = CMD_IDENT;
               default:  s_d.bdata = CMD_RESET;
            endcase
            if (bus.ack)
            begin
               s_d.req = 1'b0;
               s_d.st  = (s_q.op == OP_IDENT) ? M_RD : M_W2;
            end
         end
         M_W2:
         begin
            // second write: erase code again, program data, or second reset
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b1;
            s_d.baddr = s_q.addr;
            case (s_q.op)
               OP_ERASE: s_d.bdata = CMD_ERASE;  // back to back, starts erase
               OP_PROG:  s_d.bdata = s_q.data;   // program write
               default:  s_d.bdata = CMD_RESET;  // two resets clear setup state
            endcase
            if (bus.ack)
            begin
               s_d.req = 1'b0;
               // polling only makes sense after the second write
               s_d.st  = (s_q.op == OP_RESET) ? M_FIN : M_POLL;
            end
         end
         M_RD:
         begin
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b0;
            s_d.baddr = s_q.addr;
            if (bus.ack)
            begin
               s_d.req    = 1'b0;
               s_d.result = bus.rdata;
               // identification mode lasts until another command
               s_d.st     = (s_q.op == OP_IDENT) ? M_EXIT : M_FIN;
            end
         end
         M_POLL, M_REPOLL:
         begin
            // device preprograms, erases and verifies alone; host only polls
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b0;
            if (bus.ack)
            begin
               s_d.req    = 1'b0;
               s_d.result = bus.rdata;
               if (poll_ok)
               begin
                  // device is back in read mode on its own
                  s_d.baddr = '0;
                  s_d.st    = (s_q.op == OP_ERASE) ? M_VERIFY : M_FIN;
               end
               else if (s_q.st == M_REPOLL)
               begin
                  // failed part accepts only polling, so no reset is written
                  s_d.fail = 1'b1;
                  s_d.st   = M_FIN;
               end
               else if (bus.rdata[TIMEOUT_STATUS_BIT])
                  s_d.st = M_REPOLL;   // bit seven may flip with bit five
            end
         end
         M_VERIFY:
         begin
            // whole array must read erased before use
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b0;
            if (bus.ack)
            begin
               s_d.req = 1'b0;
               if (bus.rdata != ERASED_BYTE)
               begin
                  s_d.fail   = 1'b1;
                  s_d.result = bus.rdata;
                  s_d.st     = M_FIN;
               end
               else if (&s_q.baddr)
                  s_d.st = M_FIN;
               else
                  s_d.baddr = s_q.baddr + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
         end
         M_EXIT:
         begin
            // leave identification mode for read mode
            s_d.req   = 1'b1;
            s_d.is_wr = 1'b1;
            s_d.bdata = CMD_READ;
            if (bus.ack)
            begin
               s_d.req = 1'b0;
               s_d.st  = M_FIN;
            end
         end
         M_FIN:
         begin
            // supply drops only when idle; a full verify keeps it up meanwhile
            s_d.vpp  = 1'b0;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = M_IDLE;
         end
         default:
            s_d.st = M_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         s_q    <= '0;
         s_q.st <= M_IDLE;
         s_q.op <= OP_READ;
      end
      else
         s_q <= s_d;
   end

   assign bus.req            = s_q.req;
   assign bus.is_wr          = s_q.is_wr;
   assign bus.addr           = s_q.baddr;
   assign bus.wdata          = s_q.bdata;
   assign busy               = s_q.busy;
   assign done               = s_q.done;
   assign fail               = s_q.fail;
   assign result             = s_q.result;
   assign programming_supply = s_q.vpp;
endmodule

/* test/fcs_host_checker.sv */
// assertions on the user port and flash pins of the sequencer host
`timescale 1ns/1ps
module fcs_host_checker
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 18
)(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              cmd_valid,
   input wire fcs_pkg::fcs_op_t  cmd_op,
   input wire logic              busy,
   input wire logic              done,
   input wire logic              fail,
   input wire logic              programming_supply,
   input wire logic              flash_ce_n,
   input wire logic              flash_oe_n,
   input wire logic              flash_we_n,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [7:0]        flash_dq_out,
   input wire logic              flash_dq_oe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_take_read;
      cmd_valid && !busy && cmd_op == OP_READ;
   endsequence
   sequence s_strobe_tail;
      !flash_we_n ##1 flash_we_n;
   endsequence
   sequence s_read_strobe;
      (!flash_oe_n && !flash_ce_n && !flash_dq_oe) [*6] ##1 flash_oe_n;
   endsequence

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_WRITE_QUALIFIED: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobe without select, high oe and driven data");
   AST_WE_WIDTH: assert property ($fell(flash_we_n) |=> s_strobe_tail)
      else $error("write strobe not two cycles wide");
   AST_WRITE_STABLE: assert property ((!flash_we_n || $rose(flash_we_n)) |-> !flash_ce_n && $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved under the write strobe");
   AST_SUPPLY_FOR_WRITE: assert property (!programming_supply |-> flash_we_n)
      else $error("write strobe with the supply off");
   AST_READ_ACCESS: assert property ($fell(flash_oe_n) |-> s_read_strobe)
      else $error("read strobe not six cycles under select");
   AST_READ_LATENCY: assert property (s_take_read |-> ##11 done)
      else $error("plain read not done eleven cycles after it was taken");
   AST_TAKE: assert property (cmd_valid && !busy |=> busy)
      else $error("request not taken while idle");
   AST_DONE_ENDS_BUSY: assert property (done |-> !busy && $past(busy))
      else $error("done without busy falling");
   AST_FAIL_WITH_DONE: assert property ($rose(fail) |=> done)
      else $error("failure raised away from done");
   AST_IDLE_GAP: assert property ($rose(flash_ce_n) |=> flash_ce_n)
      else $error("no idle cycle between bus cycles");
endmodule

bind fcs_host fcs_host_checker #(.ADDR_W(ADDR_W)) u_fcs_chk (.core_clk, .nrst, .cmd_valid,
   .cmd_op, .busy, .done, .fail, .programming_supply, .flash_ce_n, .flash_oe_n, .flash_we_n,
   .flash_addr, .flash_dq_out, .flash_dq_oe);

/* test/fcs_flash_model.sv */
// behavioural byte-wide bulk-erase flash answering the host's pin cycles
`timescale 1ns/1ps
module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter int         ADDR_W     = 3,
   parameter int         POLLS      = 3,
   parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
   parameter logic [7:0] PART_CODE  = 8'ha5   // arbitrary value
)(
   input  wire logic              programming_supply,
   input  wire logic              flash_ce_n,
   input  wire logic              flash_oe_n,
   input  wire logic              flash_we_n,
   input  wire logic [ADDR_W-1:0] flash_addr,
   input  wire logic [7:0]        flash_dq_out,
   input  wire logic              stuck,
   output logic [7:0]             flash_dq_in
);
   typedef enum int {M_RD, M_ID, M_EARM, M_PARM, M_PBSY, M_EBSY, M_DEAD} fcs_mode_t;
   fcs_mode_t         mode = M_RD;
   logic [7:0]        mem [2**ADDR_W];
   logic [ADDR_W-1:0] wa;
   logic [ADDR_W-1:0] pa;
   logic [7:0]        pd;
   int                cnt;

   initial
   begin
      foreach (mem[i]) mem[i] = 8'(i * 37) ^ 8'h3c;
      flash_dq_in = 8'h00;
   end

   always @(negedge flash_we_n)
      if (!flash_ce_n && flash_oe_n)
         wa = flash_addr;
   // a supply edge forces read mode; a failed part stays failed
   always @(programming_supply)
      if (mode != M_DEAD)
         mode = M_RD;
   always @(posedge flash_we_n)
      if (!flash_ce_n && flash_oe_n && programming_supply)
      begin
         case (mode)
            M_PARM:
            begin
               pa = wa;
               pd = flash_dq_out;
               mode = M_PBSY;
               cnt = POLLS;
            end
            M_EARM:
               if (flash_dq_out == 8'h30)
               begin
                  foreach (mem[i]) mem[i] = 8'h00;
                  mode = M_EBSY;
                  cnt = POLLS;
               end
               else
                  mode = M_RD;
            M_PBSY, M_EBSY, M_DEAD: ;
            default:
               case (flash_dq_out)
                  8'h30: mode = M_EARM;
                  8'h10, 8'h50: mode = M_PARM;
                  8'h80, 8'h90: mode = M_ID;
                  default: mode = M_RD;
               endcase
         endcase
      end

   // completion is counted in polls, so slow parts are made by raising POLLS
   // select and address move in the same step as oe, so look a little later
   always @(negedge flash_oe_n)
      #1 if (!flash_ce_n)
      begin
         if (mode == M_PBSY || mode == M_EBSY)
         begin
            cnt--;
            if (cnt <= 0 && stuck)
               mode = M_DEAD;
            else if (cnt <= 0 && mode == M_EBSY)
               foreach (mem[i]) mem[i] = 8'hff;
            else if (cnt <= 0)
               mem[pa] = mem[pa] & pd;
            if (cnt <= 0 && !stuck)
               mode = M_RD;
         end
         case (mode)
            M_EBSY: flash_dq_in = 8'h00;
            M_PBSY: flash_dq_in = {~pd[7], 7'h00};
            M_DEAD: flash_dq_in = {~pd[7], 7'h20};
            M_ID: flash_dq_in = flash_addr[0] ? PART_CODE : MAKER_CODE;
            default: flash_dq_in = mem[flash_addr];
         endcase
      end
   // released outputs show the inverse rather than holding the last byte
   always @(posedge flash_oe_n)
      flash_dq_in = ~flash_dq_in;
endmodule

/* test/tb.sv */
// self-checking bench for the flash sequencer host against a flash model
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import fcs_pkg::*;
   localparam int         AW    = 3;
   localparam logic [7:0] MAKER = 8'h5a;  // arbitrary value
   localparam logic [7:0] PART  = 8'ha5;  // arbitrary value
   logic          core_clk, nrst, cmd_valid, busy, done, fail, stuck;
   logic          programming_supply, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
   fcs_op_t       cmd_op;
   logic [AW-1:0] cmd_addr, flash_addr;
   logic [7:0]    cmd_data, result, flash_dq_out, flash_dq_in, d;
   logic [31:0]   rs;
   logic [7:0]    ref_mem [8];
   int            failures, total_checks, a;

   fcs_host #(.ADDR_W(AW)) uut (.core_clk, .nrst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
      .busy, .done, .fail, .result, .programming_supply, .flash_ce_n, .flash_oe_n,
      .flash_we_n, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
   fcs_flash_model #(.ADDR_W(AW), .POLLS(3), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
      .programming_supply, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
      .flash_dq_out, .stuck, .flash_dq_in);

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // entered and left two nanoseconds after a rising edge
   task automatic run(input fcs_op_t op, input int ad, input logic [7:0] dt);
      int n;
      cmd_op = op;
      cmd_addr = AW'(ad);
      cmd_data = dt;
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #2 cmd_valid = 1'b0;
      n = 0;
      do
      begin
         @(posedge core_clk);
         #2 n++;
      end
      while (done !== 1'b1 && n < 4000);
      if (n >= 4000)
         failures++;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial
   begin
      #(25 * 20000);
      failures++;
      tally_and_finish();
   end

   initial
   begin
      rs = 32'd81362;
      failures = 0;
      total_checks = 0;
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = '0;
      cmd_data = 8'h00;
      stuck = 1'b0;
      foreach (ref_mem[i]) ref_mem[i] = 8'(i * 37) ^ 8'h3c;
      repeat (10) @(posedge core_clk);
      #2 nrst = 1'b1;
      `CHK("supply after reset", 1'b0, programming_supply)
      for (int i = 0; i < 8; i++)
      begin
         run(OP_READ, i, 8'h00);
         `CHK("plain read", ref_mem[i], result)
      end
      run(OP_IDENT, 0, 8'h00);
      `CHK("maker code", MAKER, result)
      run(OP_IDENT, 1, 8'h00);
      `CHK("part code", PART, result)
      run(OP_ERASE, 5, 8'h00);
      `CHK("erase fail", 1'b0, fail)
      `CHK("erase poll", 8'hff, result)
      for (int i = 0; i < 8; i++)
      begin
         ref_mem[i] = 8'hff;
         run(OP_READ, i, 8'h00);
         `CHK("erased byte", ref_mem[i], result)
      end
      for (int k = 0; k < 6; k++)
      begin
         rs = xs(rs);
         a = int'(rs[2:0]);
         d = rs[15:8] & ref_mem[a];
         ref_mem[a] = d;
         run(OP_PROG, a, d);
         `CHK("program poll", ref_mem[a], result)
         `CHK("program fail", 1'b0, fail)
         run(OP_READ, a, 8'h00);
         `CHK("programmed byte", ref_mem[a], result)
      end
      run(OP_RESET, 0, 8'h00);
      `CHK("reset fail", 1'b0, fail)
      run(OP_READ, a, 8'h00);
      `CHK("read after reset", ref_mem[a], result)
      stuck = 1'b1;
      run(OP_PROG, 2, 8'h00);
      `CHK("timeout fail", 1'b1, fail)
      tally_and_finish();
   end
endmodule
